// [core/adcop_consts.vh]
// constants for the converter output port block
`ifndef ADCOP_CONSTS_VH
`define ADCOP_CONSTS_VH

// register byte offsets
`define ADCOP_OFS_CTRL        4'h0
`define ADCOP_OFS_STATUS      4'h4
`define ADCOP_OFS_COUNT       4'h8

// control register fields
`define ADCOP_CTRL_OE_N       0
`define ADCOP_CTRL_SHUTDOWN_SELECT       1
`define ADCOP_CTRL_MODE_LO    2
`define ADCOP_CTRL_MODE_HI    3
`define ADCOP_CTRL_FMT_LO     4
`define ADCOP_CTRL_FMT_HI     5
`define ADCOP_CTRL_W          6
`define ADCOP_CTRL_RST        6'h01

// output mode codes
`define ADCOP_MODE_FULL       2'h0
`define ADCOP_MODE_SIMUL      2'h1
`define ADCOP_MODE_INTER      2'h2
`define ADCOP_MODE_LVDS       2'h3

// format codes
`define ADCOP_FMT_OB_PLAIN    2'h0
`define ADCOP_FMT_OB_DCS      2'h1
`define ADCOP_FMT_TC_DCS      2'h2
`define ADCOP_FMT_TC_PLAIN    2'h3

// timing
`define ADCOP_CLK_PERIOD_NS   10
`define ADCOP_SLEEP_WAKE_NS   1000000
`define ADCOP_NAP_WAKE_ENC    100

`endif

// [core/adcop_sync.v]
// two-flop synchroniser for levels arriving from outside the clock domain
`timescale 1ns/1ps
module adcop_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rst,
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  always @(posedge clk) begin
    if (rst) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule // adcop_sync

// [core/adcop_fmt.v]
// output word formatting: number format and range flag
`timescale 1ns/1ps
module adcop_fmt #(
  parameter W = 10
) (
  input  wire [W-1:0] code_in,
  input  wire         over_in,
  input  wire         under_in,
  input  wire         twos_comp,
  output wire [W-1:0] word_out,
  output wire         flag_out
);
  // two's complement is offset binary with the top bit flipped
  assign word_out = twos_comp ? {~code_in[W-1], code_in[W-2:0]} : code_in;
  assign flag_out = over_in | under_in;
endmodule // adcop_fmt

// [core/adcop_port.v]
// converter output port: forwarded clocks, bus modes, power modes, avalon
`timescale 1ns/1ps
`include "adcop_consts.vh"

module adcop_port #(
  parameter W              = 10,
  parameter SLEEP_WAKE_CYC = `ADCOP_SLEEP_WAKE_NS / `ADCOP_CLK_PERIOD_NS,
  parameter NAP_WAKE_ENC   = `ADCOP_NAP_WAKE_ENC
) (
  input  wire         clk,
  input  wire         rst,
  input  wire [3:0]   avs_address,
  input  wire         avs_read,
  input  wire         avs_write,
  input  wire [31:0]  avs_writedata,
  output wire [31:0]  avs_readdata,
  output wire         avs_waitrequest,
  input  wire         encode_clock_in,
  input  wire [W-1:0] conv_code,
  input  wire         conv_over,
  input  wire         conv_under,
  output wire         forwarded_data_clock,
  output wire         bus_a_data_clock,
  output wire         bus_b_data_clock,
  output wire [W-1:0] bus_a_data,
  output wire [W-1:0] bus_b_data,
  output wire         bus_a_overrange_flag,
  output wire         bus_b_overrange_flag,
  output wire         bus_a_oe_n,
  output wire         bus_b_oe_n,
  output wire         data_valid
);
  localparam ST_NORMAL = 3'h0;
  localparam ST_SLEEP  = 3'h1;
  localparam ST_NAP    = 3'h2;
  localparam ST_WAKE_S = 3'h3;
  localparam ST_WAKE_N = 3'h4;

  reg [`ADCOP_CTRL_W-1:0] ctrl_q;
  reg [31:0]              rdata_q;
  reg                     wait_q;
  reg [2:0]               st_q;
  reg [1:0]               mode_q;
  reg [31:0]              wake_q;
  reg [15:0]              count_q;
  reg                     enc_d_q;
  reg                     ph_q;
  reg [W-1:0]             prev_q;
  reg                     prev_f_q;
  reg                     pa_q;
  reg                     pb_q;
  reg [W-1:0]             a_next_q;
  reg [W-1:0]             b_next_q;
  reg                     a_nf_q;
  reg                     b_nf_q;
  reg                     fwd_q;
  reg                     a_clk_q;
  reg                     b_clk_q;
  reg [W-1:0]             a_dat_q;
  reg [W-1:0]             b_dat_q;
  reg                     a_of_q;
  reg                     b_of_q;
  reg                     a_oe_n_q;
  reg                     b_oe_n_q;
  reg                     valid_q;

  wire [W+2:0] raw_async = {encode_clock_in, conv_over, conv_under, conv_code};
  wire [W+2:0] raw_sync;
  wire [W-1:0] word;
  wire         flag;

  wire         enc_lvl  = raw_sync[W+2];
  wire         enc_rise = enc_lvl & ~enc_d_q;
  wire         enc_fall = ~enc_lvl & enc_d_q;
  wire         oe_n     = ctrl_q[`ADCOP_CTRL_OE_N];
  wire         shutdown_select     = ctrl_q[`ADCOP_CTRL_SHUTDOWN_SELECT];
  wire [1:0]   mode_sel = ctrl_q[`ADCOP_CTRL_MODE_HI:`ADCOP_CTRL_MODE_LO];
  wire [1:0]   mode     = mode_q;
  wire [1:0]   fmt      = ctrl_q[`ADCOP_CTRL_FMT_HI:`ADCOP_CTRL_FMT_LO];
  wire         demux    = (mode == `ADCOP_MODE_SIMUL) ||
                          (mode == `ADCOP_MODE_INTER);
  wire         twos     = (fmt == `ADCOP_FMT_TC_DCS) ||
                          (fmt == `ADCOP_FMT_TC_PLAIN);
  wire         dcs_on   = (fmt == `ADCOP_FMT_OB_DCS) ||
                          (fmt == `ADCOP_FMT_TC_DCS);
  wire         running  = (st_q == ST_NORMAL) || (st_q == ST_WAKE_S) ||
                          (st_q == ST_WAKE_N);
  wire         step     = running & enc_rise;

  // shutdown target picked by the enable level
  function [2:0] down_state;
    input oe_level;
    begin
      if (oe_level) begin
        down_state = ST_SLEEP;
      end else begin
        down_state = ST_NAP;
      end
    end
  endfunction

  // mode change waits for an encode fall so no bus clock
  // edge is lost or doubled; a stopped encode keeps the old mode until sleep or nap, where it follows at once
  always @(posedge clk) begin
    if (rst) begin
      mode_q <= `ADCOP_MODE_FULL;
    end else if (enc_fall || !running) begin
      mode_q <= mode_sel;
    end
  end

  // pins and encode clock are asynchronous, so all pass two flops
  adcop_sync #(
    .W (W + 3)
  ) u_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in (raw_async),
    .sync_out (raw_sync)
  );

  adcop_fmt #(
    .W (W)
  ) u_fmt (
    .code_in   (raw_sync[W-1:0]),
    .over_in   (raw_sync[W+1]),
    .under_in  (raw_sync[W]),
    .twos_comp (twos),
    .word_out  (word),
    .flag_out  (flag)
  );

  // avalon slave: one wait cycle, then a single acknowledge cycle
  always @(posedge clk) begin
    if (rst) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0;
      ctrl_q  <= `ADCOP_CTRL_RST;
    end else begin
      if ((avs_read || avs_write) && wait_q) begin
        wait_q <= 1'b0;
        if (avs_address == `ADCOP_OFS_CTRL) begin
          rdata_q <= {{(32-`ADCOP_CTRL_W){1'b0}}, ctrl_q};
        end else if (avs_address == `ADCOP_OFS_STATUS) begin
          rdata_q <= {25'h0, ph_q, twos, dcs_on, valid_q, st_q};
        end else if (avs_address == `ADCOP_OFS_COUNT) begin
          rdata_q <= {16'h0, count_q};
        end else begin
          rdata_q <= 32'h0;
        end
      end else begin
        wait_q <= 1'b1;
      end
      if (avs_write && !wait_q && avs_address == `ADCOP_OFS_CTRL) begin
        ctrl_q <= avs_writedata[`ADCOP_CTRL_W-1:0];
      end
    end
  end

  // power state machine
  always @(posedge clk) begin
    if (rst) begin
      st_q   <= ST_NORMAL;
      wake_q <= 32'h0;
    end else begin
      case (st_q)
        ST_NORMAL: begin
          if (shutdown_select && oe_n) begin
            st_q <= ST_SLEEP;
          end else if (shutdown_select) begin
            st_q <= ST_NAP;
          end
        end
        ST_SLEEP, ST_NAP: begin
          wake_q <= 32'h0;
          if (shutdown_select) begin
            st_q <= down_state(oe_n);
          end else begin
            st_q <= (st_q == ST_SLEEP) ? ST_WAKE_S : ST_WAKE_N;
          end
        end
        ST_WAKE_S: begin
          // reference settle time in clk cycles
          if (shutdown_select) begin
            st_q <= down_state(oe_n);
          end else if (wake_q >= SLEEP_WAKE_CYC - 1) begin
            st_q <= ST_NORMAL;
          end else begin
            wake_q <= wake_q + 32'h1;
          end
        end
        ST_WAKE_N: begin
          if (shutdown_select) begin
            st_q <= down_state(oe_n);
          end else if (wake_q >= NAP_WAKE_ENC) begin
            st_q <= ST_NORMAL;
          end else if (enc_rise) begin
            wake_q <= wake_q + 32'h1;
          end
        end
        default: begin
          st_q <= ST_NORMAL;
        end
      endcase
    end
  end

  // sample steering, one cycle from encode rise to pending update
  always @(posedge clk) begin
    if (rst) begin
      enc_d_q  <= 1'b0;
      ph_q     <= 1'b0;
      prev_q   <= {W{1'b0}};
      prev_f_q <= 1'b0;
      pa_q     <= 1'b0;
      pb_q     <= 1'b0;
      a_next_q <= {W{1'b0}};
      b_next_q <= {W{1'b0}};
      a_nf_q   <= 1'b0;
      b_nf_q   <= 1'b0;
      count_q  <= 16'h0;
    end else begin
      enc_d_q <= enc_lvl;
      pa_q    <= 1'b0;
      pb_q    <= 1'b0;
      if (step) begin
        count_q  <= count_q + 16'h1;
        ph_q     <= ~ph_q;
        prev_q   <= word;
        prev_f_q <= flag;
        if (mode == `ADCOP_MODE_SIMUL) begin
          // both buses load on half-rate rise
          if (!ph_q) begin
            pa_q     <= 1'b1;
            pb_q     <= 1'b1;
            a_next_q <= prev_q;
            a_nf_q   <= prev_f_q;
            b_next_q <= word;
            b_nf_q   <= flag;
          end
        end else if (mode == `ADCOP_MODE_INTER) begin
          if (!ph_q) begin
            pa_q     <= 1'b1;
            a_next_q <= word;
            a_nf_q   <= flag;
          end else begin
            pb_q     <= 1'b1;
            b_next_q <= word;
            b_nf_q   <= flag;
          end
        end else begin
          pa_q     <= 1'b1;
          a_next_q <= word;
          a_nf_q   <= flag;
        end
      end else if (!running) begin
        ph_q <= 1'b0;
      end
    end
  end

  // output registers; clocks move one cycle before their data
  always @(posedge clk) begin
    if (rst) begin
      fwd_q    <= 1'b0;
      a_clk_q  <= 1'b0;
      b_clk_q  <= 1'b0;
      a_dat_q  <= {W{1'b0}};
      b_dat_q  <= {W{1'b0}};
      a_of_q   <= 1'b0;
      b_of_q   <= 1'b0;
      a_oe_n_q <= 1'b1;
      b_oe_n_q <= 1'b1;
      valid_q  <= 1'b0;
    end else begin
      fwd_q <= running & enc_lvl;
      if (!running) begin
        a_clk_q <= 1'b0;
        b_clk_q <= 1'b0;
      end else if (demux) begin
        a_clk_q <= enc_rise ? ~ph_q : ph_q;
        b_clk_q <= enc_rise ? ph_q : ~ph_q;
      end else begin
        a_clk_q <= enc_lvl;
        b_clk_q <= 1'b0;
      end
      // bus a data follows its rising clock
      if (pa_q) begin
        a_dat_q <= a_next_q;
        a_of_q  <= a_nf_q;
      end
      if (pb_q) begin
        b_dat_q <= b_next_q;
        b_of_q  <= b_nf_q;
      end
      // enable high floats data and flag; clocks keep running
      a_oe_n_q <= oe_n | ~running;
      b_oe_n_q <= oe_n | ~running | ~demux;
      // receiver relies on valid and mode
      valid_q  <= (st_q == ST_NORMAL);
    end
  end

  assign avs_readdata         = rdata_q;
  assign avs_waitrequest      = wait_q;
  assign forwarded_data_clock = fwd_q;
  assign bus_a_data_clock     = a_clk_q;
  assign bus_b_data_clock     = b_clk_q;
  assign bus_a_data           = a_dat_q;
  assign bus_b_data           = b_dat_q;
  assign bus_a_overrange_flag = a_of_q;
  assign bus_b_overrange_flag = b_of_q;
  assign bus_a_oe_n           = a_oe_n_q;
  assign bus_b_oe_n           = b_oe_n_q;
  assign data_valid           = valid_q;
endmodule // adcop_port

// [test/adcop_checker.sv]
// assertion checker for the converter output port
`timescale 1ns/1ps
module adcop_checker #(
  parameter W = 10
) (
  input wire         clk,
  input wire         rst,
  input wire         avs_read,
  input wire         avs_write,
  input wire [31:0]  avs_readdata,
  input wire         avs_waitrequest,
  input wire         encode_clock_in,
  input wire         forwarded_data_clock,
  input wire         bus_a_data_clock,
  input wire         bus_b_data_clock,
  input wire [W-1:0] bus_a_data,
  input wire [W-1:0] bus_b_data,
  input wire         bus_a_overrange_flag,
  input wire         bus_a_oe_n,
  input wire         bus_b_oe_n,
  input wire         data_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // rise needs the pin high three samples back: two synchroniser flops plus the output register
  property p_fwd;
    $rose(forwarded_data_clock) |-> $past(encode_clock_in, 3);
  endproperty
  a_fwd: assert property (p_fwd) else $error("fwd clock early");
  property p_bus_a;
    $changed(bus_a_data) |->
      $past(bus_a_data_clock) && !$past(bus_a_data_clock, 2);
  endproperty
  a_bus_a: assert property (p_bus_a) else $error("bus a edge");
  property p_bus_b;
    $changed(bus_b_data) |->
      $past(bus_b_data_clock) != $past(bus_b_data_clock, 2);
  endproperty
  a_bus_b: assert property (p_bus_b) else $error("bus b edge");
  property p_flag;
    $changed(bus_a_overrange_flag) |->
      $past(bus_a_data_clock) && !$past(bus_a_data_clock, 2);
  endproperty
  a_flag: assert property (p_flag) else $error("flag edge");
  property p_off;
    $fell(data_valid) |-> ##[0:2] (bus_a_oe_n && bus_b_oe_n);
  endproperty
  a_off: assert property (p_off) else $error("outputs driven");
  property p_ack;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_one;
    !avs_waitrequest |-> $past(avs_read || avs_write) ##1 avs_waitrequest;
  endproperty
  a_one: assert property (p_one) else $error("stray ack");
  property p_hold;
    avs_waitrequest && $past(avs_waitrequest) |-> $stable(avs_readdata);
  endproperty
  a_hold: assert property (p_hold) else $error("readdata moved");
  c_wake: cover property ($rose(data_valid));
  c_bus_b: cover property ($changed(bus_b_data));
  c_read: cover property (!avs_waitrequest && avs_read);
endmodule // adcop_checker

bind adcop_port adcop_checker #(.W(W)) u_chk (
  .clk(clk), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .encode_clock_in(encode_clock_in),
  .forwarded_data_clock(forwarded_data_clock),
  .bus_a_data_clock(bus_a_data_clock), .bus_b_data_clock(bus_b_data_clock),
  .bus_a_data(bus_a_data), .bus_b_data(bus_b_data),
  .bus_a_overrange_flag(bus_a_overrange_flag),
  .bus_a_oe_n(bus_a_oe_n), .bus_b_oe_n(bus_b_oe_n), .data_valid(data_valid));

// [test/adcop_rx.sv]
// capturing logic at the far side of the converter buses
`timescale 1ns/1ps
module adcop_rx #(
  parameter W = 10
) (
  input wire         clk,
  input wire [1:0]   mode,
  input wire         fwd_ck,
  input wire         a_ck,
  input wire         b_ck,
  input wire [W-1:0] a_dat,
  input wire [W-1:0] b_dat,
  input wire         a_of,
  input wire         b_of,
  input wire         a_oe_n,
  input wire         b_oe_n,
  output reg [W:0]   cap_a,
  output reg [W:0]   cap_b
);
  reg  a_q, b_q;
  // released lines show garbage, never the last value
  wire [W:0] a_ln = a_oe_n ? ~cap_a : {a_of, a_dat};
  wire [W:0] b_ln = b_oe_n ? ~cap_b : {b_of, b_dat};
  wire a_c = (mode == 2'h3) ? fwd_ck : a_ck;
  initial begin
    a_q = 1'b0; b_q = 1'b0; cap_a = 0; cap_b = 0;
  end
  // capture timed by forwarded clocks only
  always @(posedge clk) begin
    a_q <= a_c;
    b_q <= b_ck;
    if (a_q && !a_c) cap_a <= a_ln;
    if (mode == 2'h2 && b_q && !b_ck) cap_b <= b_ln;
    if (mode == 2'h1 && !b_q && b_ck) cap_b <= b_ln;
  end
endmodule // adcop_rx

// [test/test_adcop_port.sv]
// testbench for the converter output port
`timescale 1ns/1ps
module test_adcop_port;
  reg         clk, rst, avs_read, avs_write, encode_clock_in;
  reg  [3:0]  avs_address;
  reg  [31:0] avs_writedata, d, e;
  reg  [9:0]  conv_code;
  reg         conv_over, conv_under;
  reg  [1:0]  m;
  wire [31:0] avs_readdata;
  wire        avs_waitrequest, fwd, a_ck, b_ck, a_of, b_of, a_oe_n, b_oe_n;
  wire        data_valid;
  wire [9:0]  a_dat, b_dat;
  wire [10:0] cap_a, cap_b, ex;
  integer     err_count, total_checks, cyc, i, n;
  adcop_port #(.SLEEP_WAKE_CYC(50), .NAP_WAKE_ENC(4)) DUT (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .encode_clock_in(encode_clock_in), .conv_code(conv_code),
    .conv_over(conv_over), .conv_under(conv_under),
    .forwarded_data_clock(fwd), .bus_a_data_clock(a_ck),
    .bus_b_data_clock(b_ck), .bus_a_data(a_dat), .bus_b_data(b_dat),
    .bus_a_overrange_flag(a_of), .bus_b_overrange_flag(b_of),
    .bus_a_oe_n(a_oe_n), .bus_b_oe_n(b_oe_n), .data_valid(data_valid));
  adcop_rx u_rx (.clk(clk), .mode(m), .fwd_ck(fwd), .a_ck(a_ck), .b_ck(b_ck),
    .a_dat(a_dat), .b_dat(b_dat), .a_of(a_of), .b_of(b_of), .a_oe_n(a_oe_n),
    .b_oe_n(b_oe_n), .cap_a(cap_a), .cap_b(cap_b));
  // twos complement inverts the top bit; flag set for over or under
  assign ex = {m != 2'h0, (10'h155 + m) ^ {m[1], 9'h0}};
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // link clock unrelated in phase to clk
  initial begin
    encode_clock_in = 0;
    #3;
    forever #62.5 encode_clock_in = ~encode_clock_in;
  end
  task check(input [31:0] seen, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task bus_wr(input [3:0] a, input [31:0] v);
    begin
      @(posedge clk);
      avs_address <= a; avs_writedata <= v; avs_write <= 1'b1;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      avs_write <= 1'b0;
    end
  endtask
  task bus_rd(input [3:0] a, output [31:0] v);
    begin
      @(posedge clk);
      avs_address <= a; avs_read <= 1'b1;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      v = avs_readdata;
      avs_read <= 1'b0;
    end
  endtask
  task wait_dv;
    begin
      n = 0;
      while (data_valid !== 1'b1) begin
        @(posedge clk);
        n = n + 1;
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      report_and_stop;
    end
  end
  initial begin
    err_count = 0; total_checks = 0; cyc = 0; m = 0; rst = 1;
    avs_read = 0; avs_write = 0; avs_address = 0; avs_writedata = 0;
    conv_code = 0; conv_over = 0; conv_under = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    bus_rd(4'h0, d);
    check(d, 32'h01);
    check({a_oe_n, b_oe_n}, 2'h3);
    for (i = 0; i < 4; i = i + 1) begin
      m = i;
      conv_code <= 10'h155 + m; conv_over <= m[0]; conv_under <= m == 2'h2;
      bus_wr(4'h0, {26'h0, m, m, 2'h0});
      repeat (300) @(posedge clk);
      check(cap_a, ex);
      if (m == 2'h1 || m == 2'h2) check(cap_b, ex);
      bus_rd(4'h4, d);
      check(d & 32'h3f, {m[1], m[0] ^ m[1], 4'h8});
    end
    // count register follows encode rises, 250 cycles apart
    bus_rd(4'h8, e);
    repeat (247) @(posedge clk);
    bus_rd(4'h8, d);
    check((d - e) >= 19 && (d - e) <= 21, 1);
    // enable raised only ahead of idle
    bus_wr(4'h0, 32'h01);
    repeat (5) @(posedge clk);
    check({a_oe_n, b_oe_n, data_valid}, 3'h7);
    bus_wr(4'h0, 32'h03);
    bus_rd(4'h4, d);
    check(d & 32'h7, 32'h1);
    bus_wr(4'h0, 32'h01);
    bus_rd(4'h4, d);
    check(d & 32'h7, 32'h3);
    wait_dv;
    check(n >= 45, 1);
    bus_wr(4'h0, 32'h02);
    bus_rd(4'h4, d);
    check(d & 32'h7, 32'h2);
    check({a_oe_n, b_oe_n, fwd}, 3'h6);
    bus_wr(4'h0, 32'h00);
    bus_rd(4'h4, d);
    check(d & 32'h7, 32'h4);
    wait_dv;
    check(n >= 30, 1);
    // unmapped place reads zero and ignores writes
    bus_rd(4'hc, d);
    check(d, 0);
    bus_wr(4'hc, 32'hffff);
    bus_rd(4'h0, d);
    check(d, 0);
    report_and_stop;
  end
endmodule // test_adcop_port
